// ===== bench/alarm_status_register_bank_tb.sv
// testbench for the alarm and status register bank
`timescale 1ns/100ps
`include "asrb_consts.vh"
module alarm_status_register_bank_tb;
  reg        clk_sys = 0;
  reg        rst_n = 0;
  reg        good_sample = 0;
  reg        fifo_sync = 0;
  reg  [4:0] ev = 0;
  reg  [2:0] en = 3'h3;
  reg  [7:0] die_temp_in = 8'he7;
  reg  [7:0] r;
  wire       wr_ptr_zero = ev[4], ptr_collision = ev[3], pattern_mismatch = ev[2];
  wire       ptr_two_apart = ev[1], ptr_one_apart = ev[0];
  wire       ptr_two_apart_enable = en[1], ptr_one_apart_enable = en[0], auto_clear_after_good = en[2];
  wire       sclk, sdenb_n, sdio_in, sdio_out, sdio_oe, wr_ptr_stuck, alarm_output_pin;
  wire [3:0] scale_a, scale_b;
  int        n_errors = 0, samples_checked = 0;
  int        pos [5] = '{6, 5, 3, 1, 0};
  asrb_bank i_dut (.*);
  asrb_host i_host (.*);
  always #4 clk_sys = ~clk_sys;
  task chk(input [7:0] s, input [7:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %0t got %h want %h", $time, s, e);
    end
  endtask
  task rd(input [4:0] a, input int n, input [7:0] e);
    i_host.xfer({3'h4, a}, 8'h00, n, r);
    chk(r, e);
  endtask
  task wr(input [4:0] a, input [7:0] d);
    i_host.xfer({3'h0, a}, d, 5, r);
  endtask
  task hit(input [4:0] v);
    @(negedge clk_sys);
    ev = v;
    @(negedge clk_sys);
    ev = 0;
    repeat (4) @(negedge clk_sys);
  endtask
  // ====
  // scenarios
  task t_regs;
    rd(`ASRB_ADDR_SCALE, 5, 8'hff);
    rd(`ASRB_ADDR_MASK, 5, 8'h00);
    rd(`ASRB_ADDR_STATUS, 5, 8'h00);
    wr(5'h1f, 8'h5a);
    rd(5'h1f, 5, 8'h00);
    wr(`ASRB_ADDR_SCALE, 8'h3c);
    chk(scale_a, 4'h3);
    chk(scale_b, 4'hc);
    wr(`ASRB_ADDR_TEMP, 8'h00);
    rd(`ASRB_ADDR_TEMP, 63, 8'he7);
  endtask
  task t_alarms;
    for (int k = 0; k < 5; k++) begin
      hit(5'h10 >> k);
      chk(alarm_output_pin, 1);
      rd(`ASRB_ADDR_STATUS, 5, 8'h01 << pos[k]);
      wr(`ASRB_ADDR_STATUS, 8'h00);
      rd(`ASRB_ADDR_STATUS, 5, 8'h00);
      chk(alarm_output_pin, 0);
    end
    chk(wr_ptr_stuck, 1);
    fifo_sync = 1;
    @(negedge clk_sys);
    fifo_sync = 0;
    @(negedge clk_sys);
    chk(wr_ptr_stuck, 0);
  endtask
  task t_mask;
    wr(`ASRB_ADDR_MASK, 8'h7f);
    rd(`ASRB_ADDR_MASK, 5, 8'h7f);
    hit(5'h08);
    chk(alarm_output_pin, 0);
    rd(`ASRB_ADDR_STATUS, 5, 8'h20);
    wr(`ASRB_ADDR_MASK, 8'h00);
    chk(alarm_output_pin, 1);
    wr(`ASRB_ADDR_STATUS, 8'h00);
    en = 3'h0;
    hit(5'h03);
    rd(`ASRB_ADDR_STATUS, 5, 8'h00);
  endtask
  task t_auto;
    en = 3'h4;
    hit(5'h04);
    good_sample = 1;
    repeat (62) @(negedge clk_sys);
    chk(alarm_output_pin, 1);
    repeat (8) @(negedge clk_sys);
    good_sample = 0;
    chk(alarm_output_pin, 0);
  endtask
  task print_verdict;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk_sys);
    rst_n = 1;
    repeat (3) @(negedge clk_sys);
    t_regs;
    t_alarms;
    t_mask;
    t_auto;
    print_verdict;
  end
  initial begin
    #200us;
    n_errors++;
    print_verdict;
  end
endmodule // alarm_status_register_bank_tb

// ===== bench/asrb_chk.sv
// checker on the register bank ports
`timescale 1ns/100ps
module asrb_chk (
  input wire       clk_sys,
  input wire       rst_n,
  input wire       sdenb_n,
  input wire       sdio_oe,
  input wire       wr_ptr_zero,
  input wire       ptr_collision,
  input wire       pattern_mismatch,
  input wire       ptr_two_apart,
  input wire       ptr_one_apart,
  input wire       fifo_sync,
  input wire       auto_clear_after_good,
  input wire [3:0] scale_a,
  input wire [3:0] scale_b,
  input wire       wr_ptr_stuck,
  input wire       alarm_output_pin
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire ev = wr_ptr_zero | ptr_collision | pattern_mismatch | ptr_two_apart | ptr_one_apart;
  // ====
  // idle gaps: no frame fits in six cycles, so no register write lands there
  a_stuck_set: assert property (wr_ptr_zero && !fifo_sync |=> wr_ptr_stuck) else $error("stuck");
  a_stuck_free: assert property (fifo_sync |=> !wr_ptr_stuck) else $error("sync");
  a_stuck_cause: assert property ($rose(wr_ptr_stuck) |-> $past(wr_ptr_zero)) else $error("cause");
  a_pin_cause: assert property ($rose(alarm_output_pin) && sdenb_n && $past(sdenb_n, 6) |-> $past(ev, 2))
    else $error("pin");
  a_pin_sticky: assert property (alarm_output_pin && sdenb_n && $past(sdenb_n, 6) && !auto_clear_after_good
    |=> alarm_output_pin) else $error("drop");
  a_scale_hold: assert property (sdenb_n && $past(sdenb_n, 6) |=> $stable({scale_a, scale_b})) else $error("scale");
  a_reset_vals: assert property ($rose(rst_n) |-> {scale_a, scale_b} == 8'hff && !alarm_output_pin)
    else $error("reset");
  a_oe_release: assert property ($rose(sdenb_n) |-> ##[1:6] !sdio_oe) else $error("oe");
  c_alarm: cover property ($rose(alarm_output_pin));
  c_read: cover property ($rose(sdio_oe));
  c_sync: cover property (wr_ptr_stuck ##1 fifo_sync);
endmodule // asrb_chk
bind asrb_bank asrb_chk i_chk (.*);

// ===== bench/asrb_host.sv
// host model on the serial control pins
`timescale 1ns/100ps
module asrb_host (
  input  wire clk_sys,
  input  wire sdio_out,
  output reg  sclk = 1'b0,
  output reg  sdenb_n = 1'b1,
  output reg  sdio_in = 1'b0
);
  // n cycles per half period; 63 gives a period above one microsecond
  task automatic xfer(input [7:0] h, input [7:0] w, input int n, output [7:0] r);
    r = 8'h00;
    @(negedge clk_sys);
    sdenb_n = 0;
    for (int i = 15; i >= 0; i--) begin
      // while the device answers, the line toggles so a stale value cannot pass
      sdio_in = (i > 7) ? h[i-8] : (h[7] ? ~sdio_in : w[i]);
      repeat (n) @(negedge clk_sys);
      sclk = 1;
      if (i < 8) r[i] = sdio_out;
      repeat (n) @(negedge clk_sys);
      sclk = 0;
    end
    repeat (n) @(negedge clk_sys);
    sdenb_n = 1;
    sdio_in = ~sdio_in;
  endtask
endmodule // asrb_host

// ===== src/asrb_bank.v
// register bank for current scale, temperature, alarm mask and alarm status
`timescale 1ns/100ps
`include "asrb_consts.vh"
module asrb_bank #(
  // counter width and the run of good samples that clears the alarms
  parameter                  GOOD_CNT_W = 7,
  parameter [GOOD_CNT_W-1:0] GOOD_RUN   = `ASRB_GOOD_COUNT
) (
  input  wire       clk_sys,
  input  wire       rst_n,
  // serial control interface pins
  input  wire       sclk,
  input  wire       sdenb_n,
  input  wire       sdio_in,
  output reg        sdio_out,
  output reg        sdio_oe,
  // fifo and pattern checker events, enables and die temperature
  input  wire       wr_ptr_zero,
  input  wire       ptr_collision,
  input  wire       pattern_mismatch,
  input  wire       ptr_two_apart,
  input  wire       ptr_one_apart,
  input  wire       good_sample,
  input  wire       fifo_sync,
  input  wire       ptr_two_apart_enable,
  input  wire       ptr_one_apart_enable,
  input  wire       auto_clear_after_good,
  input  wire [7:0] die_temp_in,
  // outputs to the datapath and pin
  output reg  [3:0] scale_a,
  output reg  [3:0] scale_b,
  output reg        wr_ptr_stuck,
  output reg        alarm_output_pin
);

  // ==================================================
  // pin synchronisers
  // sclk, enable and data come from pins: two flops before any logic reads them
  reg  [1:0] sclk_s;
  reg  [1:0] sden_s;
  reg  [1:0] sdi_s;
  reg        sclk_d;
  wire       sclk_rise;
  wire       sclk_fall;
  wire       frame;
  wire       sdi;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s <= `ASRB_SYNC_LOW;
      // enable resets high so the bank wakes up outside a frame
      sden_s <= `ASRB_SYNC_HIGH;
      sdi_s  <= `ASRB_SYNC_LOW;
      sclk_d <= 1'b0;
    end else begin
      sclk_s <= {sclk_s[0], sclk};
      sden_s <= {sden_s[0], sdenb_n};
      sdi_s  <= {sdi_s[0], sdio_in};
      sclk_d <= sclk_s[1];
    end
  end
  assign sclk_rise = sclk_s[1] & ~sclk_d;
  assign sclk_fall = ~sclk_s[1] & sclk_d;
  assign frame     = ~sden_s[1];
  assign sdi       = sdi_s[1];

  // ==================================================
  // serial frame: r/w bit, 2 unused, 5 address bits, 8 data bits
  localparam [1:0] SIF_HEAD = 2'b01;
  localparam [1:0] SIF_DATA = 2'b10;
  reg  [1:0] state;
  reg  [1:0] next_state;
  reg  [3:0] bit_cnt;
  reg  [3:0] next_bit_cnt;
  reg        rd_flag;
  reg        next_rd_flag;
  reg  [6:0] hdr;
  reg  [6:0] next_hdr;
  reg  [7:0] shift_in;
  reg  [7:0] next_shift_in;
  reg  [7:0] shift_out;
  reg  [7:0] next_shift_out;
  reg        next_sdio_out;
  reg        next_sdio_oe;
  reg        wr_pulse;
  reg        next_wr_pulse;
  reg  [4:0] addr;
  reg  [4:0] next_addr;
  reg  [7:0] wdata;
  reg  [7:0] next_wdata;
  reg  [6:0] mask;
  reg  [6:0] status;
  reg  [7:0] rd_word;

  // ==================================================
  // read multiplexer
  always @* begin
    case (addr)
      `ASRB_ADDR_SCALE: begin
        rd_word = {scale_a, scale_b};
      end
      `ASRB_ADDR_TEMP: begin
        rd_word = die_temp_in;
      end
      `ASRB_ADDR_MASK: begin
        rd_word = {1'b0, mask};
      end
      `ASRB_ADDR_STATUS: begin
        rd_word = {1'b0, status};
      end
      // unmapped addresses read as zero
      default: begin
        rd_word = 8'h00;
      end
    endcase
  end

  // ==================================================
  // frame state machine
  // the temperature byte is taken live at the first read edge; a slow sclk keeps it settled
  always @* begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_rd_flag   = rd_flag;
    next_hdr       = hdr;
    next_shift_in  = shift_in;
    next_shift_out = shift_out;
    next_sdio_out  = sdio_out;
    next_sdio_oe   = sdio_oe;
    next_addr      = addr;
    next_wdata     = wdata;
    next_wr_pulse  = 1'b0;
    if (!frame) begin
      // a cut frame simply drops what was shifted so far
      next_state   = SIF_HEAD;
      next_bit_cnt = `ASRB_BIT_CNT_CLR;
      next_sdio_oe = 1'b0;
    end else begin
      case (state)
        SIF_HEAD: begin
          if (sclk_rise) begin
            next_hdr     = {hdr[5:0], sdi};
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == `ASRB_LAST_BIT) begin
              next_state   = SIF_DATA;
              next_bit_cnt = `ASRB_BIT_CNT_CLR;
              next_rd_flag = hdr[`ASRB_HDR_RW_POS];
              next_addr    = {hdr[`ASRB_HDR_ADDR_TOP:0], sdi};
            end
          end else if (sclk_fall) begin
            // release the data line once the next header starts
            next_sdio_oe = 1'b0;
          end
        end
        SIF_DATA: begin
          if (sclk_rise) begin
            next_shift_in = {shift_in[6:0], sdi};
            next_bit_cnt  = bit_cnt + 4'h1;
            if (bit_cnt == `ASRB_LAST_BIT) begin
              // further bytes in the same frame go back through the header path
              next_state    = SIF_HEAD;
              next_bit_cnt  = `ASRB_BIT_CNT_CLR;
              next_wdata    = {shift_in[6:0], sdi};
              next_wr_pulse = ~rd_flag;
            end
          end else if (sclk_fall && rd_flag) begin
            // read data driven on falling edges, msb first
            if (bit_cnt == `ASRB_BIT_CNT_CLR && !sdio_oe) begin
              next_sdio_out  = rd_word[7];
              next_shift_out = {rd_word[6:0], 1'b0};
              next_sdio_oe   = 1'b1;
            end else begin
              next_sdio_out  = shift_out[7];
              next_shift_out = {shift_out[6:0], 1'b0};
            end
          end
        end
        default: begin
          next_state   = SIF_HEAD;
          next_bit_cnt = `ASRB_BIT_CNT_CLR;
        end
      endcase
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state     <= SIF_HEAD;
      bit_cnt   <= `ASRB_BIT_CNT_CLR;
      rd_flag   <= 1'b0;
      hdr       <= 7'h00;
      shift_in  <= 8'h00;
      shift_out <= 8'h00;
      sdio_out  <= 1'b0;
      sdio_oe   <= 1'b0;
      wr_pulse  <= 1'b0;
      addr      <= 5'h00;
      wdata     <= 8'h00;
    end else begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      rd_flag   <= next_rd_flag;
      hdr       <= next_hdr;
      shift_in  <= next_shift_in;
      shift_out <= next_shift_out;
      sdio_out  <= next_sdio_out;
      sdio_oe   <= next_sdio_oe;
      wr_pulse  <= next_wr_pulse;
      addr      <= next_addr;
      wdata     <= next_wdata;
    end
  end

  // ==================================================
  // write decode
  wire wr_scale;
  wire wr_mask;
  wire wr_status;
  assign wr_scale  = wr_pulse && addr == `ASRB_ADDR_SCALE;
  assign wr_mask   = wr_pulse && addr == `ASRB_ADDR_MASK;
  // writes to the temperature or an unmapped address land nowhere
  assign wr_status = wr_pulse && addr == `ASRB_ADDR_STATUS;

  // ==================================================
  // alarm events
  reg  [6:0] events;
  always @* begin
    events = 7'h00;
    events[`ASRB_BIT_ZERO] = wr_ptr_zero;
    events[`ASRB_BIT_COLL] = ptr_collision;
    events[`ASRB_BIT_PATT] = pattern_mismatch;
    events[`ASRB_BIT_TWO]  = ptr_two_apart & ptr_two_apart_enable;
    events[`ASRB_BIT_ONE]  = ptr_one_apart & ptr_one_apart_enable;
  end

  // ==================================================
  // good sample run
  localparam [GOOD_CNT_W-1:0] GOOD_LAST = GOOD_RUN - 1'b1;
  reg  [GOOD_CNT_W-1:0] good_cnt;
  reg  [GOOD_CNT_W-1:0] next_good_cnt;
  wire                  auto_clr;
  assign auto_clr = auto_clear_after_good && good_cnt == GOOD_LAST && good_sample;
  always @* begin
    // any bad sample or event restarts the run
    if (!good_sample || |events || auto_clr) begin
      next_good_cnt = {GOOD_CNT_W{1'b0}};
    end else if (good_cnt == GOOD_LAST) begin
      // saturate: a long clean run seen while auto clear was off still counts
      next_good_cnt = good_cnt;
    end else begin
      next_good_cnt = good_cnt + 1'b1;
    end
  end

  // ==================================================
  // register updates
  reg  [3:0] next_scale_a;
  reg  [3:0] next_scale_b;
  reg  [6:0] next_mask;
  reg  [6:0] next_status;
  reg        next_wr_ptr_stuck;
  reg        next_alarm_output_pin;
  always @* begin
    next_scale_a = scale_a;
    next_scale_b = scale_b;
    next_mask    = mask;
    if (wr_scale) begin
      next_scale_a = wdata[`ASRB_SCALE_A_TOP:`ASRB_SCALE_A_LOW];
      next_scale_b = wdata[`ASRB_SCALE_B_TOP:`ASRB_SCALE_B_LOW];
    end
    if (wr_mask) begin
      next_mask = wdata[`ASRB_MASK_TOP:0];
    end
  end
  always @* begin
    // sticky, cleared by write or auto clear; a new event wins
    if (wr_status || auto_clr) begin
      next_status = events & `ASRB_STATUS_USED;
    end else begin
      next_status = (status | events) & `ASRB_STATUS_USED;
    end
  end
  always @* begin
    if (fifo_sync) begin
      next_wr_ptr_stuck = 1'b0;
    end else if (wr_ptr_zero) begin
      next_wr_ptr_stuck = 1'b1;
    end else begin
      next_wr_ptr_stuck = wr_ptr_stuck;
    end
  end
  always @* begin
    // unmasked alarms drive the pin, one clock behind the status
    next_alarm_output_pin = |(status & ~mask);
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scale_a          <= `ASRB_SCALE_A_RESET;
      scale_b          <= `ASRB_SCALE_B_RESET;
      mask             <= `ASRB_MASK_RESET;
      status           <= `ASRB_STATUS_RESET;
      good_cnt         <= {GOOD_CNT_W{1'b0}};
      wr_ptr_stuck     <= 1'b0;
      alarm_output_pin <= 1'b0;
    end else begin
      scale_a          <= next_scale_a;
      scale_b          <= next_scale_b;
      mask             <= next_mask;
      status           <= next_status;
      good_cnt         <= next_good_cnt;
      wr_ptr_stuck     <= next_wr_ptr_stuck;
      alarm_output_pin <= next_alarm_output_pin;
    end
  end

endmodule // asrb_bank

// ===== src/asrb_consts.vh
// constants for the alarm and status register bank
//
// Function
// - current scale bits 7:4 set channel A full scale, reset all ones
// - current scale bits 3:0 set channel B full scale, reset all ones
// - temperature register reads die temperature, 8-bit two's complement, read only
// - 7-bit alarm mask, reset zero, one bit per alarm, 1 masks
// - masked alarm keeps off the alarm pin but is still recorded
// - alarm status resets to zero and a host write clears it
// - status bit 6 sets when the write pointer is all zeros
// - all-zero write pointer stays stuck until the next sync
// - status bit 5 sets on pointer overrun or underrun
// - status bit 3 sets on test pattern mismatch
// - status bit 1 sets when pointers are two apart
// - status bit 0 sets when pointers are one apart
// - two-apart and one-apart alarms only when their enables are set
// - auto clear after 64 consecutive good samples when enabled
`ifndef ASRB_CONSTS_VH
`define ASRB_CONSTS_VH
// ==================================================
// register offsets
`define ASRB_ADDR_SCALE      5'h04
`define ASRB_ADDR_TEMP       5'h05
`define ASRB_ADDR_MASK       5'h06
`define ASRB_ADDR_STATUS     5'h07
// ==================================================
// reset values and fields
`define ASRB_SCALE_RESET     8'hff
`define ASRB_MASK_RESET      7'h00
`define ASRB_STATUS_RESET    7'h00
`define ASRB_STATUS_USED     7'h6b
`define ASRB_BIT_ZERO        6
`define ASRB_BIT_COLL        5
`define ASRB_BIT_PATT        3
`define ASRB_BIT_TWO         1
`define ASRB_BIT_ONE         0
`define ASRB_GOOD_COUNT      7'h40
// ==================================================
// serial frame layout and field positions
`define ASRB_LAST_BIT        4'h7
`define ASRB_BIT_CNT_CLR     4'h0
`define ASRB_HDR_RW_POS      6
`define ASRB_HDR_ADDR_TOP    3
`define ASRB_SCALE_A_TOP     7
`define ASRB_SCALE_A_LOW     4
`define ASRB_SCALE_B_TOP     3
`define ASRB_SCALE_B_LOW     0
`define ASRB_MASK_TOP        6
`define ASRB_SCALE_A_RESET   4'hf
`define ASRB_SCALE_B_RESET   4'hf
`define ASRB_SYNC_LOW        2'h0
`define ASRB_SYNC_HIGH       2'h3
`endif
